// ### logic/ebpm_top.sv
`timescale 1ns/1ps

// What this block does
// - the bus bit 15 pin is a plain port whenever the external bus is not enabled.
// - with the external bus enabled that pin carries muxed address/data 15.
// - in bus mode a high-address-16..19 pin is a port when its control bit is 1.
// - a control bit of 0 makes that pin drive its high address bit 16..19.
// - the pins for address bits 20 and 21 follow the same per-bit choice.
// - the bus clock pin is a port whenever the external bus is not enabled or clock out is off.
// - the bus clock is driven only with the bus enabled and clock out on.
// - each shared pin has a register bit turning its pull-up on or off.
// - on flash variants the external bus needs an externally fetched vector.
// - inputs start automotive in single-chip mode and TTL in bus mode.
// - each port bit is input, output or peripheral; outputs are push-pull.

module ebpm_top
    import ebpm_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b1
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic MODE_EXT_BUS,
    input wire logic VECTOR_EXT,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [WB_AW-1:0] WB_ADR_I,
    input wire logic [WB_SW-1:0] WB_SEL_I,
    input wire logic [WB_DW-1:0] WB_DAT_I,
    output logic [WB_DW-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic EXT_BIT15_O,
    input wire logic EXT_BIT15_OE,
    input wire logic [HA_BITS-1:0] EXT_ADDR_HI,
    input wire logic EXT_BUS_CLK,
    input wire logic [NPIN-1:0] PERIPH_O,
    input wire logic [NPIN-1:0] PIN_I,
    output logic [NPIN-1:0] PIN_O,
    output logic [NPIN-1:0] PIN_OE,
    output logic [NPIN-1:0] PIN_PU,
    output logic [NPIN-1:0] PIN_TTL,
    output logic EXT_BIT15_I,
    output logic EXT_BUS_EN
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        ebpm_phase_t phase;
        logic mode_ext;
        logic vec_ext;
        logic bus_en;
        logic clk_en;
        logic [HA_BITS-1:0] haoc;
        logic [NPIN-1:0] dat;
        logic [NPIN-1:0] dir;
        logic [NPIN-1:0] pue;
        logic [NPIN-1:0] psel;
        logic [NPIN-1:0] ilvl;
        logic [NPIN-1:0] pin_in;
        logic [NPIN-1:0] alt;
        logic [NPIN-1:0] pin_o;
        logic [NPIN-1:0] pin_oe;
        logic bit15_in;
        logic ack;
        logic [WB_DW-1:0] rdat;
    } ebpm_state_t;

    ebpm_state_t s_q;
    ebpm_state_t s_d;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic hit(
        input logic [WB_AW-1:0] adr,
        input logic [7:0] ofs
    );
        hit = (adr == ofs);
    endfunction : hit

    function automatic logic [WB_DW-1:0] zx8(input logic [7:0] v);
        zx8 = {24'h000000, v};
    endfunction : zx8

    // ****************************************
    // pin function selection
    // ****************************************
    logic [NPIN-1:0] alt_en;
    logic [NPIN-1:0] alt_o;
    logic [NPIN-1:0] alt_oe;
    logic [NPIN-1:0] cell_o;
    logic [NPIN-1:0] cell_oe;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            if (gi == PIN_BIT15) begin : g_ad
                // port only while the bus is off
                assign alt_en[gi] = s_q.bus_en;
                assign alt_o[gi] = EXT_BIT15_O;
                assign alt_oe[gi] = EXT_BIT15_OE;
            end else if (gi <= PIN_HA_LAST) begin : g_ha
                // control bit 1 hands the pin back to the port
                assign alt_en[gi] =
                    s_q.bus_en & ~s_q.haoc[gi-PIN_HA_FIRST];
                assign alt_o[gi] = EXT_ADDR_HI[gi-PIN_HA_FIRST];
                assign alt_oe[gi] = 1'b1;
            end else begin : g_clk
                assign alt_en[gi] = s_q.bus_en & s_q.clk_en;
                assign alt_o[gi] = EXT_BUS_CLK;
                assign alt_oe[gi] = 1'b1;
            end

            ebpm_pin_cell u_cell (
                .alt_en(alt_en[gi]),
                .alt_o(alt_o[gi]),
                .alt_oe(alt_oe[gi]),
                .psel(s_q.psel[gi]),
                .periph_o(PERIPH_O[gi]),
                .port_dat(s_q.dat[gi]),
                .port_dir(s_q.dir[gi]),
                .pin_o(cell_o[gi]),
                .pin_oe(cell_oe[gi])
            );
        end
    endgenerate

    // ****************************************
    // bus decode
    // ****************************************
    logic req;
    logic wr;
    logic wr_lo;

    assign req = WB_CYC_I & WB_STB_I & ~s_q.ack;
    assign wr = req & WB_WE_I;
    // writable registers are one byte wide, so only lane 0 writes
    assign wr_lo = wr & WB_SEL_I[0];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;

        // straps are caught on the first clock after reset release
        if (s_q.phase == PH_STRAP) begin
            s_d.phase = PH_RUN;
            s_d.mode_ext = MODE_EXT_BUS;
            s_d.vec_ext = VECTOR_EXT;
            // flash parts refuse the bus in internal vector mode
            s_d.bus_en = MODE_EXT_BUS & (VECTOR_EXT | ~FLASH_VARIANT);
            s_d.ilvl = MODE_EXT_BUS ? ILVL_TTL : ILVL_AUTO;
        end

        s_d.pin_in = PIN_I;
        s_d.bit15_in = PIN_I[PIN_BIT15];
        s_d.alt = alt_en;
        s_d.pin_o = cell_o;
        s_d.pin_oe = cell_oe;

        // single-cycle classic ack, dropped the cycle after
        s_d.ack = req;
        s_d.rdat = '0;

        if (req && !WB_WE_I) begin
            unique case (1'b1)
                hit(WB_ADR_I, OFS_CTRL):
                    s_d.rdat[CTRL_CLK_EN_BIT] = s_q.clk_en;
                hit(WB_ADR_I, OFS_HAOC):
                    s_d.rdat = zx8({2'b00, s_q.haoc});
                hit(WB_ADR_I, OFS_DATA):
                    s_d.rdat = zx8(s_q.dat);
                hit(WB_ADR_I, OFS_DIR):
                    s_d.rdat = zx8(s_q.dir);
                hit(WB_ADR_I, OFS_PUE):
                    s_d.rdat = zx8(s_q.pue);
                hit(WB_ADR_I, OFS_PSEL):
                    s_d.rdat = zx8(s_q.psel);
                hit(WB_ADR_I, OFS_ILVL):
                    s_d.rdat = zx8(s_q.ilvl);
                hit(WB_ADR_I, OFS_PIN_IN):
                    s_d.rdat = zx8(s_q.pin_in);
                hit(WB_ADR_I, OFS_STATUS): begin
                    s_d.rdat[ST_BUS_EN_BIT] = s_q.bus_en;
                    s_d.rdat[ST_MODE_EXT_BIT] = s_q.mode_ext;
                    s_d.rdat[ST_VEC_EXT_BIT] = s_q.vec_ext;
                    s_d.rdat[ST_ALT_LSB +: NPIN] = s_q.alt;
                end
                default: s_d.rdat = '0;
            endcase
        end

        // a write in the strap cycle is acked but discarded, not applied later
        if (wr_lo && s_q.phase == PH_RUN) begin
            unique case (1'b1)
                hit(WB_ADR_I, OFS_CTRL):
                    s_d.clk_en = WB_DAT_I[CTRL_CLK_EN_BIT];
                hit(WB_ADR_I, OFS_HAOC):
                    s_d.haoc = WB_DAT_I[HA_BITS-1:0];
                hit(WB_ADR_I, OFS_DATA):
                    s_d.dat = WB_DAT_I[NPIN-1:0];
                hit(WB_ADR_I, OFS_DIR):
                    s_d.dir = WB_DAT_I[NPIN-1:0];
                hit(WB_ADR_I, OFS_PUE):
                    s_d.pue = WB_DAT_I[NPIN-1:0];
                hit(WB_ADR_I, OFS_PSEL):
                    s_d.psel = WB_DAT_I[NPIN-1:0];
                hit(WB_ADR_I, OFS_ILVL):
                    s_d.ilvl = WB_DAT_I[NPIN-1:0];
                default: s_d.ilvl = s_d.ilvl;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_q.phase <= PH_STRAP;
            s_q.mode_ext <= 1'b0;
            s_q.vec_ext <= 1'b0;
            s_q.bus_en <= 1'b0;
            s_q.clk_en <= RST_CLK_EN;
            s_q.haoc <= RST_HAOC;
            s_q.dat <= RST_DATA;
            s_q.dir <= RST_DIR;
            s_q.pue <= RST_PUE;
            s_q.psel <= RST_PSEL;
            s_q.ilvl <= ILVL_AUTO;
            s_q.pin_in <= '0;
            s_q.alt <= '0;
            s_q.pin_o <= '0;
            s_q.pin_oe <= '0;
            s_q.bit15_in <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdat <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs, all straight from flops
    // ****************************************
    assign WB_DAT_O = s_q.rdat;
    assign WB_ACK_O = s_q.ack;
    // drivers always push-pull; no open-drain option
    assign PIN_O = s_q.pin_o;
    assign PIN_OE = s_q.pin_oe;
    assign PIN_PU = s_q.pue;
    assign PIN_TTL = s_q.ilvl;
    assign EXT_BIT15_I = s_q.bit15_in;
    assign EXT_BUS_EN = s_q.bus_en;

endmodule : ebpm_top

// ### pkg/ebpm_pkg.sv
package ebpm_pkg;

    // ****************************************
    // pin layout
    // ****************************************
    localparam int NPIN = 8;
    localparam int HA_BITS = 6;
    localparam int PIN_BIT15 = 0;
    localparam int PIN_HA_FIRST = 1;
    localparam int PIN_HA_LAST = 6;
    localparam int PIN_BUSCLK = 7;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;
    localparam int WB_SW = 4;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HAOC = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_DIR = 8'h0C;
    localparam logic [7:0] OFS_PUE = 8'h10;
    localparam logic [7:0] OFS_PSEL = 8'h14;
    localparam logic [7:0] OFS_ILVL = 8'h18;
    localparam logic [7:0] OFS_PIN_IN = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_CLK_EN_BIT = 0;
    localparam int ST_BUS_EN_BIT = 0;
    localparam int ST_MODE_EXT_BIT = 1;
    localparam int ST_VEC_EXT_BIT = 2;
    localparam int ST_ALT_LSB = 8;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic RST_CLK_EN = 1'b0;
    localparam logic [HA_BITS-1:0] RST_HAOC = 6'h00;
    localparam logic [NPIN-1:0] RST_DATA = 8'h00;
    localparam logic [NPIN-1:0] RST_DIR = 8'h00;
    localparam logic [NPIN-1:0] RST_PUE = 8'h00;
    localparam logic [NPIN-1:0] RST_PSEL = 8'h00;
    localparam logic [NPIN-1:0] ILVL_AUTO = 8'h00;
    localparam logic [NPIN-1:0] ILVL_TTL = 8'hFF;

    // ****************************************
    // state types
    // ****************************************
    typedef enum logic [1:0] {
        PH_STRAP = 2'b00,
        PH_RUN = 2'b01
    } ebpm_phase_t;

endpackage : ebpm_pkg

// ### logic/ebpm_pin_cell.sv
`timescale 1ns/1ps

module ebpm_pin_cell (
    input wire logic alt_en,
    input wire logic alt_o,
    input wire logic alt_oe,
    input wire logic psel,
    input wire logic periph_o,
    input wire logic port_dat,
    input wire logic port_dir,
    output logic pin_o,
    output logic pin_oe
);

    // ****************************************
    // per-pin function mux
    // ****************************************
    always_comb begin
        if (alt_en) begin
            // port data and direction have no say here
            pin_o = alt_o;
            pin_oe = alt_oe;
        end else if (psel) begin
            pin_o = periph_o;
            pin_oe = port_dir;
        end else begin
            pin_o = port_dat;
            pin_oe = port_dir;
        end
    end

endmodule : ebpm_pin_cell

// ### sim/ebpm_sva.sv
`timescale 1ns/1ps

// ****************
// pin mux checker
// ****************
module ebpm_sva
    import ebpm_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b1
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic MODE_EXT_BUS,
    input wire logic VECTOR_EXT,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [WB_DW-1:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic EXT_BIT15_O,
    input wire logic EXT_BIT15_OE,
    input wire logic [NPIN-1:0] PIN_I,
    input wire logic [NPIN-1:0] PIN_O,
    input wire logic [NPIN-1:0] PIN_OE,
    input wire logic [NPIN-1:0] PIN_TTL,
    input wire logic EXT_BIT15_I,
    input wire logic EXT_BUS_EN
);
    logic strap_bus;
    assign strap_bus = MODE_EXT_BUS & (VECTOR_EXT | ~FLASH_VARIANT);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_BUS_EN: assert property (
        RST_N && !$past(RST_N) |=> EXT_BUS_EN == $past(strap_bus))
        else $error("bus enable differs from straps");
    AST_TTL_INIT: assert property (
        RST_N && !$past(RST_N) |=>
        PIN_TTL == ($past(MODE_EXT_BUS) ? ILVL_TTL : ILVL_AUTO))
        else $error("initial input level wrong");
    AST_STRAP_HOLD: assert property (
        $past(RST_N) && $past(RST_N, 2) |-> $stable(EXT_BUS_EN))
        else $error("bus mode changed after strap");
    AST_MUXED_ADDR_DATA_BIT15_ALT: assert property (
        EXT_BUS_EN && $past(EXT_BUS_EN) |-> PIN_O[0] == $past(EXT_BIT15_O)
        && PIN_OE[0] == $past(EXT_BIT15_OE))
        else $error("bit 15 pin not on bus");
    AST_MUXED_ADDR_DATA_BIT15_IN: assert property (
        $past(RST_N) |-> EXT_BIT15_I == $past(PIN_I[0]))
        else $error("bit 15 input not returned");
    AST_ACK_NEXT: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("no ack one cycle after request");
    AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
        else $error("read data outside ack");
endmodule : ebpm_sva

bind ebpm_top ebpm_sva #(.FLASH_VARIANT(FLASH_VARIANT)) ebpm_sva_i (
    .CLK(CLK), .RST_N(RST_N), .MODE_EXT_BUS(MODE_EXT_BUS),
    .VECTOR_EXT(VECTOR_EXT), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EXT_BIT15_O(EXT_BIT15_O),
    .EXT_BIT15_OE(EXT_BIT15_OE), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .PIN_TTL(PIN_TTL), .EXT_BIT15_I(EXT_BIT15_I),
    .EXT_BUS_EN(EXT_BUS_EN));

// ### sim/ebpm_pads.sv
`timescale 1ns/1ps

// ****************
// far side pads
// ****************
module ebpm_pads
    import ebpm_pkg::*;
(
    input wire logic clk,
    input wire logic [NPIN-1:0] pin_o,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [NPIN-1:0] pin_pu,
    input wire logic [NPIN-1:0] ext_en,
    input wire logic [NPIN-1:0] ext_val,
    output logic [NPIN-1:0] pin_i
);
    // floating lines toggle so a stale level never passes
    logic [NPIN-1:0] float_q = 8'h55;
    always @(posedge clk) float_q <= ~float_q;
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pu | float_q));
endmodule : ebpm_pads

// ### sim/tb_top.sv
`timescale 1ns/1ps

// ****************
// bench
// ****************
module tb_top
    import ebpm_pkg::*;
;
    logic clk = 0, rst_n = 0, mode = 0, vec = 0, bclk = 0;
    logic cyc = 0, stb = 0, we = 0, ack, ad15o = 0, ad15oe = 0, ad15i, ben;
    logic [7:0] adr = 8'h00, per = 8'h00, pin_i, pin_o, pin_oe, pin_pu;
    logic [7:0] pin_ttl, een = 8'h00, ev = 8'h00, d, dir, ps, pue;
    logic [31:0] wdat = 32'h0, rdat, rq;
    logic [5:0] ahi = 6'h00, haoc;
    logic ce, be;
    int seed = 66, n_errors = 0, cmp_count = 0;

    always #4 clk = ~clk;

    ebpm_top ebpm_top_i (.CLK(clk), .RST_N(rst_n), .MODE_EXT_BUS(mode),
        .VECTOR_EXT(vec), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .EXT_BIT15_O(ad15o), .EXT_BIT15_OE(ad15oe),
        .EXT_ADDR_HI(ahi), .EXT_BUS_CLK(bclk), .PERIPH_O(per),
        .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PU(pin_pu),
        .PIN_TTL(pin_ttl), .EXT_BIT15_I(ad15i), .EXT_BUS_EN(ben));
    ebpm_pads ebpm_pads_i (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .ext_en(een), .ext_val(ev), .pin_i(pin_i));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] dv);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dv;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        chk({31'h0, ack}, 32'h1);
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // alt pins take bus values, the rest port data or peripheral
    function automatic logic [15:0] exp_pins();
        logic [7:0] alt, av, aoe, o, oe;
        alt = {be & ce, {6{be}} & ~haoc, be};
        av = {bclk, ahi, ad15o};
        aoe = {7'h7F, ad15oe};
        o = (alt & av) | (~alt & ((ps & per) | (~ps & d)));
        oe = (alt & aoe) | (~alt & dir);
        return {o, oe};
    endfunction : exp_pins

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    initial begin
        for (int c = 0; c < 3; c++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            mode <= (c != 1);
            vec <= (c != 2);
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
            repeat (2) @(posedge clk);
            be = mode & vec;
            chk({24'h0, pin_ttl}, mode ? ILVL_TTL : ILVL_AUTO);
            wb(1'b0, OFS_STATUS, 32'h0);
            // status also shows the per-pin alt map in bits 15:8
            chk(rq, {16'h0, 1'b0, {7{be}}, 5'h0, vec, mode, be});
            wb(1'b1, 8'h40, 32'hFF);
            wb(1'b0, 8'h40, 32'h0);
            chk(rq, 32'h0);
            for (int k = 0; k < 12; k++) begin
                haoc = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($random(seed));
                {ce, d, dir, ps, pue} = 33'($random(seed));
                if (k < 2) dir = 8'h00;
                wb(1'b1, OFS_CTRL, {31'h0, ce});
                wb(1'b1, OFS_HAOC, {26'h0, haoc});
                wb(1'b1, OFS_DATA, {24'h0, d});
                wb(1'b1, OFS_DIR, {24'h0, dir});
                wb(1'b1, OFS_PSEL, {24'h0, ps});
                wb(1'b1, OFS_PUE, {24'h0, pue});
                {ad15o, ad15oe, ahi, bclk, per, een, ev} <= 33'($random(seed));
                repeat (3) @(posedge clk);
                chk({16'h0, pin_o, pin_oe}, {16'h0, exp_pins()});
                chk({24'h0, pin_pu}, {24'h0, pue});
                wb(1'b1, OFS_ILVL, {24'h0, pue});
                chk({24'h0, pin_ttl}, {24'h0, pue});
                wb(1'b0, OFS_HAOC, 32'h0);
                chk(rq, {26'h0, haoc});
            end
            $display("test %0d done", c);
        end
        finish_test();
    end
endmodule : tb_top
